/* oad_top.sv */
// Operand address decoder with AXI4-Lite register slave
// Function
// - Three modes only when extended set enabled
// - Word: six opcode, d, a, 8-bit f
// - a=0, f>=60h selects Direct Forced
// - Forced f maps to 3F60h..3FFFh, bank 63
// - Forced mode never reaches below 60h
// - a=0, f<=5Fh selects Indexed Literal Offset
// - Indexed address is pointer plus f
// - a=1 always selects Direct Long
// - Long bank comes from bank select
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "oad_cfg.svh"
module oad_top
   import oad_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr,
   output logic             addr_valid,
   output logic [13:0]      addr,
   output logic [2:0]       mode,
   output logic             dest_is_file,
   output logic             is_add_wreg_to_file,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef struct packed {
      logic        ext_en;
      logic [13:0] iptr;
      logic [5:0]  bank;
      logic        aw_got;
      logic [3:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        addr_valid;
      logic [13:0] addr;
      logic [2:0]  mode;
      logic        dest;
      logic        is_add;
   } oad_state_type;

   oad_state_type s_q;
   oad_state_type s_d;
   logic [13:0]   calc_addr;
   oad_mode_type  calc_mode;

   // ----------------------------------------
   // Address former
   // ----------------------------------------
   oad_addr_calc u_calc (
      .instr  (instr),
      .ext_en (s_q.ext_en),
      .iptr   (s_q.iptr),
      .bank   (s_q.bank),
      .addr   (calc_addr),
      .mode   (calc_mode)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.addr_valid = instr_valid;
      if (instr_valid) begin
         s_d.addr   = calc_addr;
         s_d.mode   = calc_mode;
         s_d.dest   = instr[`OAD_DEST_BIT];
         s_d.is_add = instr[`OAD_OPC_MSB:`OAD_OPC_LSB] == `OAD_OPC_ADD_WREG;
      end
      // Write channel capture, either order
      if (s_axi_awvalid && !s_q.aw_got) begin
         s_d.aw_got  = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_got) begin
         s_d.w_got  = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = 2'h0;
         unique case (s_q.aw_addr)
            `OAD_REG_CTRL: begin
               if (s_q.w_strb[0]) s_d.ext_en = s_q.w_data[0];
            end
            `OAD_REG_IPTR: begin
               if (s_q.w_strb[0]) s_d.iptr[7:0] = s_q.w_data[7:0];
               if (s_q.w_strb[1]) s_d.iptr[13:8] = s_q.w_data[13:8];
            end
            `OAD_REG_BANK: begin
               if (s_q.w_strb[0]) s_d.bank = s_q.w_data[5:0];
            end
            `OAD_REG_STAT: ;
            default: s_d.bresp = 2'h2;
         endcase
      end
      if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
      // Read channel
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = 2'h0;
         unique case (s_axi_araddr)
            `OAD_REG_CTRL: s_d.rdata = {31'h0, s_q.ext_en};
            `OAD_REG_IPTR: s_d.rdata = {18'h0, s_q.iptr};
            `OAD_REG_BANK: s_d.rdata = {26'h0, s_q.bank};
            `OAD_REG_STAT: s_d.rdata = {12'h0, s_q.mode, s_q.addr_valid, 2'h0, s_q.addr};
            default: begin
               s_d.rdata = 32'h0;
               s_d.rresp = 2'h2;
            end
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q        <= '0;
         s_q.ext_en <= `OAD_CTRL_RST;
         s_q.iptr   <= `OAD_IPTR_RST;
         s_q.bank   <= `OAD_BANK_RST;
         s_q.mode   <= OAD_MODE_LONG;
      end else begin
         s_q <= s_d;
      end
   end

   assign addr_valid          = s_q.addr_valid;
   assign addr                = s_q.addr;
   assign mode                = s_q.mode;
   assign dest_is_file        = s_q.dest;
   assign is_add_wreg_to_file = s_q.is_add;
   assign s_axi_awready       = !s_q.aw_got;
   assign s_axi_wready        = !s_q.w_got;
   assign s_axi_bvalid        = s_q.bvalid;
   assign s_axi_bresp         = s_q.bresp;
   assign s_axi_arready       = !s_q.rvalid;
   assign s_axi_rvalid        = s_q.rvalid;
   assign s_axi_rdata         = s_q.rdata;
   assign s_axi_rresp         = s_q.rresp;
endmodule : oad_top
`default_nettype wire

/* oad_cfg.svh */
// Constants for the operand address decoder
`ifndef OAD_CFG_SVH
`define OAD_CFG_SVH

// ----------------------------------------
// Instruction field positions
// ----------------------------------------
`define OAD_FILE_LSB      0
`define OAD_FILE_MSB      7
`define OAD_ACCESS_BIT    8
`define OAD_DEST_BIT      9
`define OAD_OPC_LSB       10
`define OAD_OPC_MSB       15
`define OAD_OPC_ADD_WREG  6'h09
`define OAD_FORCED_MIN    8'h60
`define OAD_FORCED_BANK   6'h3f

// ----------------------------------------
// Register map
// ----------------------------------------
`define OAD_REG_CTRL      4'h0
`define OAD_REG_IPTR      4'h4
`define OAD_REG_BANK      4'h8
`define OAD_REG_STAT      4'hc
`define OAD_CTRL_RST      1'h0
`define OAD_IPTR_RST      14'h0000
`define OAD_BANK_RST      6'h00

`endif

/* oad_pkg.sv */
// Types for the operand address decoder
package oad_pkg;
   typedef enum logic [2:0] {
      OAD_MODE_FORCED  = 3'b001,
      OAD_MODE_INDEXED = 3'b010,
      OAD_MODE_LONG    = 3'b100
   } oad_mode_type;
endpackage : oad_pkg

/* oad_addr_calc.sv */
// Combinational address former for one operand
`timescale 1ns/1ps
`default_nettype none
`include "oad_cfg.svh"
module oad_addr_calc
   import oad_pkg::*;
(
   input  wire logic [15:0]  instr,
   input  wire logic         ext_en,
   input  wire logic [13:0]  iptr,
   input  wire logic [5:0]   bank,
   output var  logic [13:0]  addr,
   output var  oad_mode_type mode
);
   logic [7:0] file_f;
   logic       acc;

   always_comb begin
      file_f = instr[`OAD_FILE_MSB:`OAD_FILE_LSB];
      acc    = instr[`OAD_ACCESS_BIT];
      if (acc || !ext_en) begin
         mode = OAD_MODE_LONG;
         addr = {bank, file_f};
      end else if (file_f >= `OAD_FORCED_MIN) begin
         mode = OAD_MODE_FORCED;
         addr = {`OAD_FORCED_BANK, file_f};
      end else begin
         mode = OAD_MODE_INDEXED;
         addr = iptr + {6'h00, file_f};
      end
   end
endmodule : oad_addr_calc
`default_nettype wire

/* oad_top_monitor.sv */
// Port checker for the operand decoder
`timescale 1ns/1ps
`default_nettype none
module oad_monitor (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        instr_valid,
   input wire logic [15:0] instr,
   input wire logic        addr_valid,
   input wire logic [13:0] addr,
   input wire logic [2:0]  mode,
   input wire logic        dest_is_file,
   input wire logic        is_add_wreg_to_file
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence low_take;
      instr_valid && !instr[8];
   endsequence
   echo_valid_a: assert property (instr_valid |=> addr_valid)
      else $error("no addr_valid");
   idle_hold_a: assert property (!instr_valid |=> !addr_valid && $stable(addr))
      else $error("addr moved");
   dest_bit_a: assert property (instr_valid |=> dest_is_file == $past(instr[9]))
      else $error("bad dest");
   opcode_flag_a: assert property (instr_valid |=> is_add_wreg_to_file == ($past(instr[15:10]) == 6'h09))
      else $error("bad opcode flag");
   long_mode_a: assert property (instr_valid && instr[8] |=> mode == 3'b100 && addr[7:0] == $past(instr[7:0]))
      else $error("bad long");
   forced_pick_a: assert property (low_take ##0 instr[7:0] >= 8'h60 |=> mode == 3'b100 ||
      (mode == 3'b001 && addr == {6'h3f, $past(instr[7:0])})) else $error("bad forced");
   low_pick_a: assert property (low_take ##0 instr[7:0] < 8'h60 |=> mode != 3'b001)
      else $error("forced below 60");
   forced_range_a: assert property (addr_valid && mode == 3'b001 |-> addr >= 14'h3f60)
      else $error("forced range");
endmodule : oad_monitor
bind oad_top oad_monitor u_oad_monitor (.clk, .nrst, .instr_valid, .instr, .addr_valid, .addr, .mode,
   .dest_is_file, .is_add_wreg_to_file);
`default_nettype wire

/* oad_mem_model.sv */
// Data-memory side: captures each decoded address
`timescale 1ns/1ps
`default_nettype none
module oad_mem_model (
   input wire logic        clk,
   input wire logic        addr_valid,
   input wire logic [13:0] addr,
   output var logic [13:0] seen_q
);
   always_ff @(posedge clk) begin
      if (addr_valid) seen_q <= addr;
   end
endmodule : oad_mem_model
`default_nettype wire

/* testbench.sv */
// Bench for the operand decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = '0, nrst = '0, instr_valid = '0, addr_valid, dest_is_file, is_add_wreg_to_file;
   logic [15:0] instr = '0;
   logic [13:0] addr, seen_q;
   logic [2:0] mode;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int n_fail = 0, tests_run = 0;
   oad_top u_oad_top (.*);
   oad_mem_model u_oad_mem_model (.clk, .addr_valid, .addr, .seen_q);
   initial forever #2.5 clk = ~clk;
   task automatic chk(string w, logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", w, e, s);
      end
   endtask : chk
   task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] r);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, r);
   endtask : wr
   task automatic rd(logic [3:0] a, logic [1:0] r, logic [31:0] d);
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rresp", s_axi_rresp, r);
      chk("rdata", s_axi_rdata, d);
   endtask : rd
   task automatic dec(logic [15:0] i, logic [13:0] a, logic [2:0] m);
      @(posedge clk);
      {instr_valid, instr} <= {1'b1, i};
      @(posedge clk);
      instr_valid <= 1'b0;
      @(posedge clk);
      #1;
      chk("addr", seen_q, a);
      chk("mode", mode, m);
      chk("dest", dest_is_file, i[9]);
      chk("opc", is_add_wreg_to_file, i[15:10] == 6'h09);
   endtask : dec
   task automatic t_regs();
      rd(4'h0, 2'h0, 32'h0);
      rd(4'h4, 2'h0, 32'h0);
      rd(4'h2, 2'h2, 32'h0);
      wr(4'h2, 32'h1, 2'h2);
      rd(4'h0, 2'h0, 32'h0);
      wr(4'h8, 32'h3e, 2'h0);
      rd(4'h8, 2'h0, 32'h3e);
      $display("regs done");
   endtask : t_regs
   task automatic t_off();
      dec(16'h2470, 14'h3e70, 3'b100);
      $display("disabled done");
   endtask : t_off
   task automatic t_forced_idx();
      wr(4'h0, 32'h1, 2'h0);
      dec(16'h2660, 14'h3f60, 3'b001);
      dec(16'h24ff, 14'h3fff, 3'b001);
      wr(4'h4, 32'h3fff, 2'h0);
      dec(16'h245f, 14'h005e, 3'b010);
      dec(16'h2400, 14'h3fff, 3'b010);
      $display("forced indexed done");
   endtask : t_forced_idx
   task automatic t_long();
      dec(16'h2560, 14'h3e60, 3'b100);
      wr(4'h8, 32'h0, 2'h0);
      dec(16'h01ff, 14'h00ff, 3'b100);
      rd(4'hc, 2'h0, 32'h000800ff);
      $display("long done");
   endtask : t_long
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   initial begin
      #20000;
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_off();
      t_forced_idx();
      t_long();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
